// ---- hdl/uad_pin_if.sv ----
// Purpose: Carries pin selections and levels between control and pin mux
// Assumes: Both ends on ref_clk
// Notes:   Levels arrive already synchronised and registered
`timescale 1ns/100ps
interface uad_pin_if;
	logic [4:0] pull_sel;
	logic [4:0] vbus_sel;
	logic [4:0] det_sel;
	logic [4:0] wake_sel;
	logic       pull_on;
	logic       wake_on;
	logic       vbus_lvl;
	logic       det_lvl;
	modport ctl (output pull_sel, vbus_sel, det_sel, wake_sel, pull_on, wake_on,
		input vbus_lvl, det_lvl);
	modport mux (input pull_sel, vbus_sel, det_sel, wake_sel, pull_on, wake_on,
		output vbus_lvl, det_lvl);
endinterface : uad_pin_if

// ---- hdl/uad_pin_mux.sv ----
// Purpose: Maps selected general pins onto detach, VBUS, pull-up and wake
// Assumes: Inputs already synchronised
// Notes:   Unassigned pins stay undriven
`timescale 1ns/100ps
module uad_pin_mux (
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	// Pins
	input  wire logic [uad_pkg::NPIN-1:0]   gpio_sync,
	output logic      [uad_pkg::NPIN-1:0]   gpio_out,
	output logic      [uad_pkg::NPIN-1:0]   gpio_oe_n,
	// Control side
	uad_pin_if.mux                          pins
);
	typedef struct packed {
		logic                     vbus;
		logic                     det;
		logic [uad_pkg::NPIN-1:0] out;
		logic [uad_pkg::NPIN-1:0] oe_n;
	} uad_mux_t;
	uad_mux_t s_r, s_nxt;
	always_comb
	begin
		s_nxt      = s_r;
		// Code 16 reads as low: an absent pin never detaches
		s_nxt.vbus = (pins.vbus_sel < uad_pkg::PIN_NONE) && gpio_sync[pins.vbus_sel[3:0]];
		s_nxt.det  = (pins.det_sel < uad_pkg::PIN_NONE) && gpio_sync[pins.det_sel[3:0]];
		for (int i = 0; i < uad_pkg::NPIN; i++)
		begin
			s_nxt.out[i]  = 1'b0;
			s_nxt.oe_n[i] = 1'b1;
			if (pins.wake_sel == 5'(i))
			begin
				s_nxt.out[i]  = pins.wake_on;
				s_nxt.oe_n[i] = 1'b0;
			end
			else if (pins.pull_sel == 5'(i) && pins.pull_on)
			begin
				s_nxt.out[i]  = 1'b1;
				s_nxt.oe_n[i] = 1'b0;
			end
		end
	end
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s_r <= '{vbus: 1'b0, det: 1'b0, out: '0, oe_n: '1};
		else
			s_r <= s_nxt;
	end
	assign pins.vbus_lvl = s_r.vbus;
	assign pins.det_lvl  = s_r.det;
	assign gpio_out      = s_r.out;
	assign gpio_oe_n     = s_r.oe_n;
endmodule : uad_pin_mux

// ---- hdl/uad_pkg.sv ----
// Purpose: Shared constants and types of the USB attach/detach control
// Assumes: 16 general pins, 5-bit pin selection codes
// Notes:   Code 16 in a pin selection means no pin (internal pull-up)
package uad_pkg;
	localparam int          NPIN          = 16;
	localparam int          SELW          = 5;
	localparam logic [4:0]  PIN_NONE      = 5'h10;
	// Register byte offsets
	localparam logic [3:0]  A_CTRL        = 4'h0;
	localparam logic [3:0]  A_PINSEL      = 4'h4;
	localparam logic [3:0]  A_STATUS      = 4'h8;
	localparam logic [3:0]  A_DESC        = 4'hC;
	// Control fields
	localparam int          CTRL_READY    = 0;
	localparam int          CTRL_SELF     = 1;
	localparam int          CTRL_AUDIO    = 2;
	localparam int          CTRL_WAKE     = 3;
	// Pin selection field positions
	localparam int          PS_PULL       = 0;
	localparam int          PS_VBUS       = 8;
	localparam int          PS_DET        = 16;
	localparam int          PS_WAKE       = 24;
	localparam logic [31:0] PINSEL_RST    = 32'h10101010;
	// Status fields
	localparam int          ST_LSB        = 0;
	localparam int          ST_VBUS       = 4;
	localparam int          ST_DET        = 5;
	localparam int          ST_LOCK       = 6;
	localparam int          ST_CFGERR     = 7;
	localparam int          ST_PULL       = 8;
	localparam int          ST_RADIO      = 9;
	localparam int          ST_WAKE       = 10;
	// Descriptor fields
	localparam int          DS_SELF       = 8;
	localparam int          DS_AUDIO      = 9;
	localparam int          BUS_MA        = 200;
	localparam int          MA_PER_UNIT   = 2;
	localparam logic [7:0]  MAXP_BUS      = 8'(BUS_MA / MA_PER_UNIT);
	localparam logic [7:0]  MAXP_SELF     = 8'h00;
	typedef enum logic [2:0] {
		UAD_IDLE,
		UAD_DETACHED,
		UAD_WAIT_VBUS,
		UAD_ATTACHED,
		UAD_SUSPEND
	} uad_state_t;
endpackage : uad_pkg

// ---- hdl/uad_sync.sv ----
// Purpose: Two-flop synchroniser for a vector of pin inputs
// Assumes: Bits are independent levels
// Notes:   First stage feeds only the second
`timescale 1ns/100ps
module uad_sync #(
	parameter int W = 16
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_r <= '0;
			q      <= '0;
		end
		else
		begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule : uad_sync

// ---- hdl/usb_attach_detach_control.sv ----
// Purpose: Attach, detach, power-mode and wake control of a USB peripheral port
// Assumes: USB core on ref_clk reports suspend; pins are asynchronous
// Notes:   Pin selections freeze at the first ready write until reset
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
// How it works
// - Pull D+ up only when ready
// - Internal pull-up default, external pin optional
// - Self-powered: no pull-up without VBUS
// - VBUS sense pin chosen by number
// - Pull-up selection 16 means internal
// - Bus powered: descriptor asks 200 mA
// - Bus-powered suspend keeps radio off
// - Detach and wake pins chosen by number
// - Detach high: lines float, pull-up off
// - Detach low: pull-up back, await enumeration
// - Wake output high only while detached
// - No in-band wake while detached
// - Peripheral role only, never host
// - Endpoint set: wireless or audio
module usb_attach_detach_control (
	// Clock and reset
	input  wire logic                     ref_clk,
	input  wire logic                     reset_n,
	// Register port
	input  wire logic [3:0]               reg_addr,
	input  wire logic [31:0]              reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output logic      [31:0]              reg_rdata,
	// General pins
	input  wire logic [uad_pkg::NPIN-1:0] gpio_in,
	output logic      [uad_pkg::NPIN-1:0] gpio_out,
	output logic      [uad_pkg::NPIN-1:0] gpio_oe_n,
	// USB core
	input  wire logic                     usb_suspend,
	output logic                          dp_pullup_en,
	output logic                          usb_lines_hiz,
	output logic                          usb_rmt_wake,
	output logic      [7:0]               usb_max_power,
	output logic                          usb_self_pwr,
	output logic                          usb_ep_audio,
	output logic                          usb_dev_role,
	// Radio
	output logic                          radio_en
);
	typedef struct packed {
		uad_pkg::uad_state_t st;
		logic        ready;
		logic        self_pw;
		logic        audio;
		logic        locked;
		logic        wake_req;
		logic [4:0]  pull_sel;
		logic [4:0]  vbus_sel;
		logic [4:0]  det_sel;
		logic [4:0]  wake_sel;
		logic [31:0] rdata;
		logic        pull_int;
		logic        hiz;
		logic        rmt;
		logic        radio;
		logic [7:0]  maxp;
		logic        selfattr;
		logic        ep_audio;
		logic        role;
	} uad_ctl_t;

	logic [1:0]               rst_q;
	logic                     rst_n;
	logic [uad_pkg::NPIN-1:0] gpio_sync;
	uad_ctl_t                 s_r;
	uad_ctl_t                 s_nxt;
	logic                     pull_on;
	logic                     vbus_ok;
	logic                     cfg_err;
	logic                     wr_ctrl;
	logic                     wr_pin;
	logic [31:0]              status;
	logic [31:0]              desc;
	logic [31:0]              pinsel;

	uad_pin_if pins ();

	// Reset release through two flops
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			rst_q <= 2'h0;
		else
			rst_q <= {rst_q[0], 1'b1};
	end
	assign rst_n = rst_q[1];

	uad_sync #(.W(uad_pkg::NPIN)) u_sync (
		.clk   (ref_clk),
		.rst_n (rst_n),
		.d     (gpio_in),
		.q     (gpio_sync)
	);

	uad_pin_mux u_mux (
		.clk       (ref_clk),
		.rst_n     (rst_n),
		.gpio_sync (gpio_sync),
		.gpio_out  (gpio_out),
		.gpio_oe_n (gpio_oe_n),
		.pins      (pins)
	);

	// Pull-up live only once ready and attached
	assign pull_on = (s_r.st == uad_pkg::UAD_ATTACHED) || (s_r.st == uad_pkg::UAD_SUSPEND);
	assign vbus_ok = !s_r.self_pw || pins.vbus_lvl;
	// Self-powered on the internal pull-up is not compliant
	assign cfg_err = s_r.self_pw && (s_r.pull_sel == uad_pkg::PIN_NONE);
	assign wr_ctrl = reg_wr && (reg_addr == uad_pkg::A_CTRL);
	assign wr_pin  = reg_wr && (reg_addr == uad_pkg::A_PINSEL);

	assign pins.pull_sel = s_r.pull_sel;
	assign pins.vbus_sel = s_r.vbus_sel;
	assign pins.det_sel  = s_r.det_sel;
	assign pins.wake_sel = s_r.wake_sel;
	assign pins.pull_on  = pull_on && (s_r.pull_sel != uad_pkg::PIN_NONE);
	assign pins.wake_on  = s_r.wake_req && (s_r.st == uad_pkg::UAD_DETACHED);

	always_comb
	begin
		pinsel = 32'h0;
		pinsel[uad_pkg::PS_PULL +: 5] = s_r.pull_sel;
		pinsel[uad_pkg::PS_VBUS +: 5] = s_r.vbus_sel;
		pinsel[uad_pkg::PS_DET  +: 5] = s_r.det_sel;
		pinsel[uad_pkg::PS_WAKE +: 5] = s_r.wake_sel;
		status = 32'h0;
		status[uad_pkg::ST_LSB +: 3]  = s_r.st;
		status[uad_pkg::ST_VBUS]      = pins.vbus_lvl;
		status[uad_pkg::ST_DET]       = pins.det_lvl;
		status[uad_pkg::ST_LOCK]      = s_r.locked;
		status[uad_pkg::ST_CFGERR]    = cfg_err;
		status[uad_pkg::ST_PULL]      = pull_on;
		status[uad_pkg::ST_RADIO]     = s_r.radio;
		status[uad_pkg::ST_WAKE]      = pins.wake_on;
		desc = 32'h0;
		desc[7:0]                     = s_r.maxp;
		desc[uad_pkg::DS_SELF]        = s_r.selfattr;
		desc[uad_pkg::DS_AUDIO]       = s_r.ep_audio;
	end

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.rmt = 1'b0;
		// Register writes; configuration ignored once locked
		if (wr_ctrl)
		begin
			s_nxt.ready = reg_wdata[uad_pkg::CTRL_READY];
			if (reg_wdata[uad_pkg::CTRL_READY])
				s_nxt.locked = 1'b1;
			if (!s_r.locked)
			begin
				s_nxt.self_pw = reg_wdata[uad_pkg::CTRL_SELF];
				s_nxt.audio   = reg_wdata[uad_pkg::CTRL_AUDIO];
			end
		end
		if (wr_pin && !s_r.locked)
		begin
			s_nxt.pull_sel = reg_wdata[uad_pkg::PS_PULL +: 5];
			s_nxt.vbus_sel = reg_wdata[uad_pkg::PS_VBUS +: 5];
			s_nxt.det_sel  = reg_wdata[uad_pkg::PS_DET  +: 5];
			s_nxt.wake_sel = reg_wdata[uad_pkg::PS_WAKE +: 5];
		end
		// Attach state follows ready, detach, VBUS and suspend
		if (!s_nxt.ready)
			s_nxt.st = uad_pkg::UAD_IDLE;
		else if (pins.det_lvl)
			s_nxt.st = uad_pkg::UAD_DETACHED;
		else if (!vbus_ok)
			s_nxt.st = uad_pkg::UAD_WAIT_VBUS;
		else if (usb_suspend)
			s_nxt.st = uad_pkg::UAD_SUSPEND;
		else
			s_nxt.st = uad_pkg::UAD_ATTACHED;
		// Wake request: out-of-band when detached, in-band only on the bus
		case (s_r.st)
			uad_pkg::UAD_DETACHED:
			begin
				if (wr_ctrl && reg_wdata[uad_pkg::CTRL_WAKE])
					s_nxt.wake_req = 1'b1;
				else if (wr_ctrl)
					s_nxt.wake_req = 1'b0;
			end
			uad_pkg::UAD_SUSPEND:
			begin
				s_nxt.wake_req = 1'b0;
				s_nxt.rmt = wr_ctrl && reg_wdata[uad_pkg::CTRL_WAKE];
			end
			default:
				s_nxt.wake_req = 1'b0;
		endcase
		if (s_nxt.st != uad_pkg::UAD_DETACHED)
			s_nxt.wake_req = 1'b0;
		// Outputs track the next state so they align with it
		s_nxt.pull_int = ((s_nxt.st == uad_pkg::UAD_ATTACHED) ||
			(s_nxt.st == uad_pkg::UAD_SUSPEND)) && (s_nxt.pull_sel == uad_pkg::PIN_NONE);
		s_nxt.hiz      = !((s_nxt.st == uad_pkg::UAD_ATTACHED) ||
			(s_nxt.st == uad_pkg::UAD_SUSPEND));
		// Suspend budget leaves no room for the radio on bus power
		s_nxt.radio    = !((s_nxt.st == uad_pkg::UAD_SUSPEND) && !s_nxt.self_pw);
		s_nxt.maxp     = s_nxt.self_pw ? uad_pkg::MAXP_SELF : uad_pkg::MAXP_BUS;
		s_nxt.selfattr = s_nxt.self_pw;
		s_nxt.ep_audio = s_nxt.audio;
		s_nxt.role     = 1'b1;
		// Read data valid in the next cycle only
		s_nxt.rdata = 32'h0;
		if (reg_rd)
		begin
			case (reg_addr)
				uad_pkg::A_CTRL:
					s_nxt.rdata = {28'h0, s_r.wake_req, s_r.audio, s_r.self_pw, s_r.ready};
				uad_pkg::A_PINSEL: s_nxt.rdata = pinsel;
				uad_pkg::A_STATUS: s_nxt.rdata = status;
				uad_pkg::A_DESC:   s_nxt.rdata = desc;
				default:           s_nxt.rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_r          <= '0;
			s_r.st       <= uad_pkg::UAD_IDLE;
			s_r.pull_sel <= uad_pkg::PINSEL_RST[uad_pkg::PS_PULL +: 5];
			s_r.vbus_sel <= uad_pkg::PINSEL_RST[uad_pkg::PS_VBUS +: 5];
			s_r.det_sel  <= uad_pkg::PINSEL_RST[uad_pkg::PS_DET  +: 5];
			s_r.wake_sel <= uad_pkg::PINSEL_RST[uad_pkg::PS_WAKE +: 5];
			s_r.hiz      <= 1'b1;
			s_r.radio    <= 1'b1;
			s_r.maxp     <= uad_pkg::MAXP_BUS;
			s_r.role     <= 1'b1;
		end
		else
			s_r <= s_nxt;
	end

	assign reg_rdata     = s_r.rdata;
	assign dp_pullup_en  = s_r.pull_int;
	assign usb_lines_hiz = s_r.hiz;
	assign usb_rmt_wake  = s_r.rmt;
	assign usb_max_power = s_r.maxp;
	assign usb_self_pwr  = s_r.selfattr;
	assign usb_ep_audio  = s_r.ep_audio;
	assign usb_dev_role  = s_r.role;
	assign radio_en      = s_r.radio;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// Detach seen this cycle still shows last cycle's pull-up, so check state
	chk_pull_ready: assert property (dp_pullup_en |-> s_r.ready && pull_on)
		else $error("pull-up on while not ready");
	chk_pull_internal: assert property (dp_pullup_en |-> s_r.pull_sel == uad_pkg::PIN_NONE)
		else $error("internal pull-up with external pin selected");
	chk_vbus_gate: assert property (s_r.ready && s_r.self_pw && !pins.vbus_lvl
		&& !pins.det_lvl && !wr_ctrl
		|=> s_r.st == uad_pkg::UAD_WAIT_VBUS && !pins.pull_on)
		else $error("pull-up not dropped on missing VBUS");
	// Power request follows the attribute in the same cycle
	chk_bus_current: assert property (!s_r.self_pw |-> usb_max_power == uad_pkg::MAXP_BUS)
		else $error("bus-powered current request not 200 mA");
	chk_radio_off: assert property (s_r.st == uad_pkg::UAD_SUSPEND && !s_r.self_pw |-> !radio_en)
		else $error("radio on during bus-powered suspend");
	chk_detach_hiz: assert property (s_r.ready && pins.det_lvl
		|=> usb_lines_hiz && !dp_pullup_en && !pins.pull_on)
		else $error("lines driven while detached");
	chk_reattach: assert property (s_r.st == uad_pkg::UAD_DETACHED && s_r.ready
		&& !pins.det_lvl && vbus_ok && !usb_suspend && !wr_ctrl
		|=> s_r.st == uad_pkg::UAD_ATTACHED)
		else $error("no reconnect after detach release");
	chk_wake_det: assert property (pins.wake_on |-> s_r.st == uad_pkg::UAD_DETACHED)
		else $error("wake output outside detach");
	chk_wake_clear: assert property (s_r.st != uad_pkg::UAD_DETACHED |-> !s_r.wake_req)
		else $error("wake request pending outside detach");
	chk_no_rmt: assert property (usb_rmt_wake |-> $past(s_r.st) == uad_pkg::UAD_SUSPEND)
		else $error("in-band wake while not on the bus");
	chk_dev_role: assert property (##1 usb_dev_role)
		else $error("host role reported");
	chk_cfg_lock: assert property (s_r.locked && wr_pin |=> $stable(s_r.pull_sel)
		&& $stable(s_r.det_sel) && $stable(s_r.vbus_sel) && $stable(s_r.wake_sel))
		else $error("pin selection changed after lock");

	cov_detach: cover property (s_r.st == uad_pkg::UAD_ATTACHED ##1
		s_r.st == uad_pkg::UAD_DETACHED ##[1:50] s_r.st == uad_pkg::UAD_ATTACHED);
	cov_suspend: cover property (s_r.st == uad_pkg::UAD_SUSPEND && !radio_en);
	cov_wake: cover property (pins.wake_on);
	cov_rmt: cover property (usb_rmt_wake);
endmodule : usb_attach_detach_control

// ---- verif/tb.sv ----
// Purpose: Self-checking bench of the USB attach/detach control
// Assumes: Pins 3/5 detach/wake, later pins 2/4 pull-up/VBUS
// Notes:   Pin levels resolve bench drive against design enables
`timescale 1ns/100ps
module tb;
	logic                       ref_clk, reset_n, reg_wr, reg_rd, suspend_cmd, attached;
	logic [3:0]                 reg_addr;
	logic [31:0]                reg_wdata, reg_rdata, rd_val;
	logic [uad_pkg::NPIN-1:0]   gpio_in, gpio_out, gpio_oe_n, pin_drv;
	logic                       dp_pullup_en, usb_lines_hiz, usb_rmt_wake, usb_suspend;
	logic                       usb_self_pwr, usb_ep_audio, usb_dev_role, radio_en;
	logic [7:0]                 usb_max_power;
	int                         failures, checked, cycles, wake_pulses;
	typedef struct {logic [31:0] ctrl; logic [7:0] maxp; logic self; logic aud;} uad_row_t;
	uad_row_t rows [4] = '{'{32'h0, 8'h64, 1'h0, 1'h0}, '{32'h2, 8'h00, 1'h1, 1'h0},
		'{32'h4, 8'h64, 1'h0, 1'h1}, '{32'h6, 8'h00, 1'h1, 1'h1}};

	// Wire level: design wins where it drives
	assign gpio_in = (gpio_out & ~gpio_oe_n) | (pin_drv & gpio_oe_n);
	usb_attach_detach_control dut (
		.ref_clk       (ref_clk),
		.reset_n       (reset_n),
		.reg_addr      (reg_addr),
		.reg_wdata     (reg_wdata),
		.reg_wr        (reg_wr),
		.reg_rd        (reg_rd),
		.reg_rdata     (reg_rdata),
		.gpio_in       (gpio_in),
		.gpio_out      (gpio_out),
		.gpio_oe_n     (gpio_oe_n),
		.usb_suspend   (usb_suspend),
		.dp_pullup_en  (dp_pullup_en),
		.usb_lines_hiz (usb_lines_hiz),
		.usb_rmt_wake  (usb_rmt_wake),
		.usb_max_power (usb_max_power),
		.usb_self_pwr  (usb_self_pwr),
		.usb_ep_audio  (usb_ep_audio),
		.usb_dev_role  (usb_dev_role),
		.radio_en      (radio_en)
	);
	uad_host_model host (.ref_clk(ref_clk), .dp_pullup_en(dp_pullup_en),
		.usb_lines_hiz(usb_lines_hiz), .ext_pull(gpio_in[2]), .suspend_cmd(suspend_cmd),
		.usb_suspend(usb_suspend), .attached(attached));

	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// Pulses last one cycle, so count them rather than sample
	always @(posedge ref_clk)
	begin
		cycles++;
		if (usb_rmt_wake === 1'b1)
			wake_pulses++;
		if (cycles == 5000)
		begin
			failures++;
			finish_test();
		end
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge ref_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 rd_val = reg_rdata;
	endtask : rd
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : wait_cyc
	task automatic do_reset();
		@(posedge ref_clk);
		reset_n <= 1'b0;
		wait_cyc(10);
		@(posedge ref_clk);
		reset_n <= 1'b1;
		wait_cyc(3);
	endtask : do_reset
	task automatic finish_test();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : finish_test

	initial
	begin
		{reset_n, reg_wr, reg_rd, suspend_cmd, reg_addr, reg_wdata, pin_drv} = '0;
		{failures, checked, cycles, wake_pulses} = '0;
		do_reset();
		check("pullup", dp_pullup_en, 32'h0);
		check("role", usb_dev_role, 32'h1);
		check("radio", radio_en, 32'h1);
		rd(uad_pkg::A_PINSEL);
		check("pinsel", rd_val, 32'h10101010);
		rd(4'h2);
		check("unmapped", rd_val, 32'h0);
		wr(uad_pkg::A_PINSEL, 32'h05031010);
		foreach (rows[i])
		begin
			wr(uad_pkg::A_CTRL, rows[i].ctrl);
			wait_cyc(2);
			check("maxp", usb_max_power, rows[i].maxp);
			check("self", usb_self_pwr, rows[i].self);
			check("audio", usb_ep_audio, rows[i].aud);
			check("early pullup", dp_pullup_en, 32'h0);
		end
		// Bus powered, internal pull-up; this write locks the setup
		wr(uad_pkg::A_CTRL, 32'h1);
		wait_cyc(3);
		check("pullup", dp_pullup_en, 32'h1);
		check("hiz", usb_lines_hiz, 32'h0);
		check("attach", attached, 32'h1);
		rd(uad_pkg::A_STATUS);
		check("status att", rd_val, 32'h00000343);
		rd(uad_pkg::A_DESC);
		check("desc bus", rd_val, 32'h00000064);
		wr(uad_pkg::A_CTRL, 32'h3);
		wr(uad_pkg::A_PINSEL, 32'h0);
		rd(uad_pkg::A_PINSEL);
		check("frozen pinsel", rd_val, 32'h05031010);
		check("frozen self", usb_self_pwr, 32'h0);
		// Suspend keeps the radio off; in-band wake allowed
		@(posedge ref_clk);
		suspend_cmd <= 1'b1;
		wait_cyc(4);
		check("radio susp", radio_en, 32'h0);
		wake_pulses = 0;
		wr(uad_pkg::A_CTRL, 32'h9);
		wait_cyc(3);
		check("rmt wake", wake_pulses, 32'h1);
		@(posedge ref_clk);
		suspend_cmd <= 1'b0;
		wait_cyc(4);
		check("radio back", radio_en, 32'h1);
		// Detach pin 3 high
		@(posedge ref_clk);
		pin_drv[3] <= 1'b1;
		wait_cyc(6);
		check("det hiz", usb_lines_hiz, 32'h1);
		check("det pullup", dp_pullup_en, 32'h0);
		check("wake idle", gpio_out[5], 32'h0);
		wake_pulses = 0;
		wr(uad_pkg::A_CTRL, 32'h9);
		wait_cyc(4);
		check("no rmt wake", wake_pulses, 32'h0);
		check("wake pin", gpio_out[5], 32'h1);
		check("wake oe", gpio_oe_n[5], 32'h0);
		rd(uad_pkg::A_STATUS);
		check("status det", rd_val, 32'h00000661);
		rd(uad_pkg::A_CTRL);
		check("ctrl wake", rd_val, 32'h00000009);
		@(posedge ref_clk);
		pin_drv[3] <= 1'b0;
		wait_cyc(6);
		check("wake drop", gpio_out[5], 32'h0);
		check("re pullup", dp_pullup_en, 32'h1);
		check("re hiz", usb_lines_hiz, 32'h0);
		// Mid-run reset, then self powered with pull-up pin 2, VBUS pin 4
		do_reset();
		check("rst pullup", dp_pullup_en, 32'h0);
		wr(uad_pkg::A_PINSEL, 32'h10100402);
		wr(uad_pkg::A_CTRL, 32'h3);
		wait_cyc(6);
		check("no vbus oe", gpio_oe_n[2], 32'h1);
		check("no vbus att", attached, 32'h0);
		check("self maxp", usb_max_power, 32'h0);
		rd(uad_pkg::A_STATUS);
		check("status vbus", rd_val, 32'h00000242);
		@(posedge ref_clk);
		pin_drv[4] <= 1'b1;
		wait_cyc(6);
		check("ext oe", gpio_oe_n[2], 32'h0);
		check("ext out", gpio_out[2], 32'h1);
		check("ext att", attached, 32'h1);
		@(posedge ref_clk);
		pin_drv[4] <= 1'b0;
		wait_cyc(6);
		check("vbus gone", gpio_oe_n[2], 32'h1);
		finish_test();
	end
endmodule : tb

// ---- verif/uad_host_model.sv ----
// Purpose: Behavioural USB host controller facing the peripheral port
// Assumes: Attach is seen as a pull-up (internal or pin) with lines driven
// Notes:   Suspends only an attached device, and only when the bench asks
`timescale 1ns/100ps
module uad_host_model (
	// Clock
	input  wire logic ref_clk,
	// Device side
	input  wire logic dp_pullup_en,
	input  wire logic usb_lines_hiz,
	input  wire logic ext_pull,
	// Bench control
	input  wire logic suspend_cmd,
	output logic      usb_suspend,
	output logic      attached
);
	// Host is master; a floating port cannot be suspended
	initial
	begin
		attached    = 1'b0;
		usb_suspend = 1'b0;
		forever
		begin
			@(posedge ref_clk);
			attached    <= (dp_pullup_en | ext_pull) & ~usb_lines_hiz;
			usb_suspend <= suspend_cmd & attached;
		end
	end
endmodule : uad_host_model
